/* File: pkg/frdis_regs.vh */
`ifndef FRDIS_REGS_VH
`define FRDIS_REGS_VH

// Register indices; byte address is four times the index
`define FRDIS_IDX_DIN 10'h3f7
`define FRDIS_IDX_MODE 10'h3f8
`define FRDIS_IDX_ST0 10'h3f9
`define FRDIS_IDX_ST1 10'h3fa

// Mode configuration fields
`define FRDIS_MODE_IDENT 0
`define FRDIS_MODE_ENC 1
`define FRDIS_MODE_FDC_EN 2
`define FRDIS_MODE_FDC_VAL 3
`define FRDIS_MODE_RST 4'h1

// Register modes
`define FRDIS_RM_AT 2'h0
`define FRDIS_RM_ALT 2'h1
`define FRDIS_RM_THIRD 2'h2

// Rate configuration fields
`define FRDIS_RC_RATE_LO 0
`define FRDIS_RC_RATE_HI 1
`define FRDIS_RC_PRECOMP 2
`define FRDIS_RATE_RST 2'h2
`define FRDIS_PRECOMP_RST 1'b0
`define FRDIS_DENS_RST 1'b1

// Rate select codes and rates in Kbps
`define FRDIS_RS_500 2'h0
`define FRDIS_RS_300 2'h1
`define FRDIS_RS_250 2'h2
`define FRDIS_RS_1M 2'h3
`define FRDIS_KBPS_500 10'h1f4
`define FRDIS_KBPS_300 10'h12c
`define FRDIS_KBPS_250 10'h0fa
`define FRDIS_KBPS_1M 10'h3e8

// Termination codes
`define FRDIS_TC_NORMAL 2'h0
`define FRDIS_TC_ABNORMAL 2'h1
`define FRDIS_TC_INVALID 2'h2
`define FRDIS_TC_POLLING 2'h3

// Status byte 0 positions
`define FRDIS_S0_CODE_HI 7
`define FRDIS_S0_CODE_LO 6
`define FRDIS_S0_SEEK 5
`define FRDIS_S0_EQUIP 4
`define FRDIS_S0_HEAD 2

// Status byte 1 positions
`define FRDIS_S1_END 7
`define FRDIS_S1_CRC 5
`define FRDIS_S1_OVR 4
`define FRDIS_S1_NODATA 2
`define FRDIS_S1_PROT 1
`define FRDIS_S1_MARK 0

// Counts
`define FRDIS_RECAL_STEPS 7'h50
`define FRDIS_INDEX_LIMIT 2'h2

`endif

/* File: rtl/frdis_core.v */
// Overview of operation
// - Input register read-only; writes reach rate config
// - Mode AT read drives only bit 7
// - Bit 7 inverted disk change or forced value
// - Alternate bit0 low at 500K/1M rates
// - Rate select survives soft, hardware sets 250K
// - Alternate mode bits 3-6 read one
// - Third mode bit 2 returns precomp disable
// - Third mode bit 3 returns DMA gate
// - Third mode bits 4-6 read zero
// - Config write loads rate select, resets 10
// - Precomp bit stored and read in third mode only, survives soft reset
// - Density output high after hardware reset or a 500K/1M rate write
// - Status 0 bits 7:6 give termination code
// - Status 0 bit 5 marks seek finished
// - Status 0 bit 4 equipment fault
// - Status 0 bit3 zero, head, drive number
// - Status 1 bit7 end of track; 6,3 zero
// - Status 1 bit 5 CRC fault
// - Status 1 bit 4 overrun or underrun
// - Status 1 bit 2 sector not found
// - Status 1 bit 1 write protect violation
// - Status 1 bit 0 address mark absent
// - Register mode from identity and encoding bits
`timescale 1ns/1ps
`default_nettype none
`include "frdis_regs.vh"
module frdis_core #(
  parameter ADDR_W = 10
) (
  input wire sys_clk,
  input wire srst,
  input wire soft_rst,
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire [7:0] dbus_oe_n,
  input wire disk_changed,
  input wire track_zero_input,
  input wire index_input,
  input wire write_protect_in,
  input wire dma_gate_enable,
  input wire cmd_start,
  input wire cmd_end,
  input wire [1:0] termination_code,
  input wire head_number,
  input wire [1:0] drive_number,
  input wire seek_finished_ev,
  input wire recal_active,
  input wire recal_step,
  input wire rel_seek_past_zero,
  input wire beyond_last_sector,
  input wire data_xfer_done,
  input wire terminal_count,
  input wire crc_fault_ev,
  input wire overrun_ev,
  input wire sector_not_found_ev,
  input wire write_cmd_active,
  input wire id_search_active,
  input wire id_mark_found,
  input wire data_mark_missing,
  output wire [1:0] rate_select_out,
  output wire [9:0] rate_kbps_out,
  output wire precomp_disable_flag,
  output wire density_select_out
);
  reg wait_reg;
  reg [31:0] rdata_reg;
  reg [7:0] oe_n_reg;
  reg [3:0] mode_reg;
  reg [1:0] rate_sel_reg;
  reg precomp_reg;
  reg dens_reg;
  reg [9:0] kbps_reg;
  reg [1:0] code_reg;
  reg seek_reg;
  reg equip_reg;
  reg head_reg;
  reg [1:0] drive_reg;
  reg end_reg;
  reg crc_reg;
  reg ovr_reg;
  reg nodata_reg;
  reg prot_reg;
  reg mark_reg;
  reg tc_seen_reg;
  reg index_d_reg;
  reg [1:0] reg_mode;
  reg [7:0] din_view;
  reg [31:0] rdata_next;
  reg [7:0] oe_n_next;
  wire [3:0] pins_st;
  wire dchg_st;
  wire track_zero_input_st;
  wire index_st;
  wire wp_st;
  wire bus_req;
  wire take;
  wire wr_din;
  wire wr_mode;
  wire low_rate_flag;
  wire disk_bit;
  wire recal_reached;
  wire index_reached;
  wire index_rise;
  wire stat_clr;
  wire [7:0] st0;
  wire [7:0] st1;

  frdis_sync #(
    .WIDTH(4)
  ) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin_in({write_protect_in, index_input, track_zero_input, disk_changed}),
    .pin_stable(pins_st)
  );
  assign dchg_st = pins_st[0];
  assign track_zero_input_st = pins_st[1];
  assign index_st = pins_st[2];
  assign wp_st = pins_st[3];

  frdis_step_cnt #(
    .WIDTH(7),
    .LIMIT(`FRDIS_RECAL_STEPS)
  ) u_recal_cnt (
    .sys_clk(sys_clk),
    .srst(srst),
    .clear(~recal_active | soft_rst),
    .step(recal_step),
    .reached(recal_reached)
  );

  assign index_rise = index_st & ~index_d_reg;

  frdis_step_cnt #(
    .WIDTH(2),
    .LIMIT(`FRDIS_INDEX_LIMIT)
  ) u_index_cnt (
    .sys_clk(sys_clk),
    .srst(srst),
    .clear(~id_search_active | id_mark_found | soft_rst),
    .step(index_rise),
    .reached(index_reached)
  );

  // Bus handshake: one wait cycle, then a single low cycle per request
  assign bus_req = avs_read | avs_write;
  assign take = bus_req & ~wait_reg;
  // Writes to the input address go to rate config
  assign wr_din = take & avs_write & avs_byteenable[0] & (avs_address == `FRDIS_IDX_DIN);
  assign wr_mode = take & avs_write & avs_byteenable[0] & (avs_address == `FRDIS_IDX_MODE);

  // Mode select from identity and encoding
  always @* begin
    if (mode_reg[`FRDIS_MODE_IDENT]) begin
      reg_mode = `FRDIS_RM_AT;
    end else if (mode_reg[`FRDIS_MODE_ENC]) begin
      reg_mode = `FRDIS_RM_ALT;
    end else begin
      reg_mode = `FRDIS_RM_THIRD;
    end
  end

  assign low_rate_flag = (rate_sel_reg == `FRDIS_RS_300) | (rate_sel_reg == `FRDIS_RS_250);
  assign disk_bit = mode_reg[`FRDIS_MODE_FDC_EN] ? mode_reg[`FRDIS_MODE_FDC_VAL] : ~dchg_st;

  always @* begin
    din_view = 8'h00;
    din_view[7] = disk_bit;
    case (reg_mode)
      `FRDIS_RM_ALT: begin
        din_view[0] = low_rate_flag;
        din_view[2:1] = rate_sel_reg;
        din_view[6:3] = 4'hf;
      end
      `FRDIS_RM_THIRD: begin
        din_view[1:0] = rate_sel_reg;
        din_view[2] = precomp_reg;
        din_view[3] = dma_gate_enable;
        din_view[6:4] = 3'h0;
      end
      default: begin
        din_view[6:0] = 7'h00;
      end
    endcase
  end

  // Bit 3 zero, head and drive in low bits
  assign st0 = {code_reg, seek_reg, equip_reg, 1'b0, head_reg, drive_reg};
  assign st1 = {end_reg, 1'b0, crc_reg, ovr_reg, 1'b0, nodata_reg, prot_reg, mark_reg};

  always @* begin
    rdata_next = 32'h00000000;
    oe_n_next = 8'h00;
    case (avs_address)
      `FRDIS_IDX_DIN: begin
        rdata_next[7:0] = din_view;
        // AT mode leaves bits 0-6 undriven
        if (reg_mode == `FRDIS_RM_AT) begin
          rdata_next[6:0] = 7'h00;
          oe_n_next = 8'h7f;
        end
      end
      `FRDIS_IDX_MODE: begin
        rdata_next[3:0] = mode_reg;
      end
      `FRDIS_IDX_ST0: begin
        rdata_next[7:0] = st0;
      end
      `FRDIS_IDX_ST1: begin
        rdata_next[7:0] = st1;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
      oe_n_reg <= 8'hff;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
      if (bus_req & wait_reg & avs_read) begin
        rdata_reg <= rdata_next;
        oe_n_reg <= oe_n_next;
      end else if (take) begin
        oe_n_reg <= 8'hff;
      end
    end
  end

  // Rate, precomp, density and mode: soft reset leaves these alone
  always @(posedge sys_clk) begin
    if (srst) begin
      mode_reg <= `FRDIS_MODE_RST;
      rate_sel_reg <= `FRDIS_RATE_RST;
      precomp_reg <= `FRDIS_PRECOMP_RST;
      dens_reg <= `FRDIS_DENS_RST;
      kbps_reg <= `FRDIS_KBPS_250;
    end else begin
      if (wr_mode) begin
        mode_reg <= avs_writedata[3:0];
      end
      if (wr_din) begin
        // Load rate select from bits 1:0
        rate_sel_reg <= avs_writedata[`FRDIS_RC_RATE_HI:`FRDIS_RC_RATE_LO];
        // Precomp bit stored only in third mode
        if (reg_mode == `FRDIS_RM_THIRD) begin
          precomp_reg <= avs_writedata[`FRDIS_RC_PRECOMP];
        end
        dens_reg <= (avs_writedata[1:0] == `FRDIS_RS_1M) |
                    (avs_writedata[1:0] == `FRDIS_RS_500);
      end
      case (rate_sel_reg)
        `FRDIS_RS_500: kbps_reg <= `FRDIS_KBPS_500;
        `FRDIS_RS_300: kbps_reg <= `FRDIS_KBPS_300;
        `FRDIS_RS_250: kbps_reg <= `FRDIS_KBPS_250;
        default: kbps_reg <= `FRDIS_KBPS_1M;
      endcase
    end
  end

  // Status flags clear at command start; a set in the same cycle wins
  assign stat_clr = cmd_start | soft_rst;

  always @(posedge sys_clk) begin
    if (srst) begin
      code_reg <= `FRDIS_TC_NORMAL;
      seek_reg <= 1'b0;
      equip_reg <= 1'b0;
      head_reg <= 1'b0;
      drive_reg <= 2'h0;
      end_reg <= 1'b0;
      crc_reg <= 1'b0;
      ovr_reg <= 1'b0;
      nodata_reg <= 1'b0;
      prot_reg <= 1'b0;
      mark_reg <= 1'b0;
      tc_seen_reg <= 1'b0;
      index_d_reg <= 1'b0;
    end else begin
      index_d_reg <= index_st;
      // Termination code captured at command end
      if (cmd_end) begin
        code_reg <= termination_code;
      end else if (stat_clr) begin
        code_reg <= `FRDIS_TC_NORMAL;
      end
      // Head and drive follow the current selection
      head_reg <= head_number;
      drive_reg <= drive_number;
      // Seek, relative seek or recalibrate done
      seek_reg <= seek_finished_ev | (seek_reg & ~stat_clr);
      // Track zero missing after 80 steps, or past zero
      equip_reg <= (recal_active & recal_reached & ~track_zero_input_st) | rel_seek_past_zero |
                   (equip_reg & ~stat_clr);
      tc_seen_reg <= terminal_count | (tc_seen_reg & ~stat_clr);
      // Beyond last sector, or transfer done without terminal count
      end_reg <= beyond_last_sector | (data_xfer_done & ~tc_seen_reg & ~terminal_count) |
                 (end_reg & ~stat_clr);
      // CRC mismatch in ID or data field
      crc_reg <= crc_fault_ev | (crc_reg & ~stat_clr);
      ovr_reg <= overrun_ev | (ovr_reg & ~stat_clr);
      nodata_reg <= sector_not_found_ev | (nodata_reg & ~stat_clr);
      // Write protect during a write command
      prot_reg <= (write_cmd_active & wp_st) | (prot_reg & ~stat_clr);
      // Two index pulses without ID mark, or data mark missing
      mark_reg <= (id_search_active & index_reached) | data_mark_missing |
                  (mark_reg & ~stat_clr);
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign dbus_oe_n = oe_n_reg;
  assign rate_select_out = rate_sel_reg;
  assign rate_kbps_out = kbps_reg;
  assign precomp_disable_flag = precomp_reg;
  assign density_select_out = dens_reg;
endmodule
`default_nettype wire

/* File: rtl/frdis_step_cnt.v */
`timescale 1ns/1ps
`default_nettype none
module frdis_step_cnt #(
  parameter WIDTH = 7,
  parameter [WIDTH-1:0] LIMIT = 7'h50
) (
  input wire sys_clk,
  input wire srst,
  input wire clear,
  input wire step,
  output wire reached
);
  reg [WIDTH-1:0] cnt_reg;
  always @(posedge sys_clk) begin
    if (srst || clear) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else if (step && cnt_reg != LIMIT) begin
      cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  assign reached = (cnt_reg == LIMIT);
endmodule
`default_nettype wire

/* File: rtl/frdis_sync.v */
`timescale 1ns/1ps
`default_nettype none
module frdis_sync #(
  parameter WIDTH = 4
) (
  input wire sys_clk,
  input wire srst,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_stable
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg stable_reg;
      always @(posedge sys_clk) begin
        if (srst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          s1_reg <= pin_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // Accept a level only once two stages agree
          if (s2_reg == s3_reg) begin
            stable_reg <= s3_reg;
          end
        end
      end
      assign pin_stable[i] = stable_reg;
    end
  endgenerate
endmodule
`default_nettype wire

/* File: tb/frdis_host.sv */
`timescale 1ns/1ps
`default_nettype none
module frdis_host (
  input wire logic sys_clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [9:0] avs_address = 10'h000,
  output logic avs_read = 1'b0,
  output logic avs_write = 1'b0,
  output logic [31:0] avs_writedata = 32'h00000000,
  output logic [3:0] avs_byteenable = 4'h1
);
  task xfer(input logic w, input logic [9:0] ad, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= ad;
    avs_writedata <= {24'h000000, (ad == 10'h3f7) ? d & 8'h07 : d};
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest && n < 40);
    if (avs_waitrequest) begin
      tb.error_cnt++;
      tb.close_out;
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~avs_writedata;
  endtask
endmodule
`default_nettype wire

/* File: tb/frdis_props.sv */
`timescale 1ns/1ps
`default_nettype none
module frdis_props #(
  parameter ADDR_W = 10
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic soft_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] dbus_oe_n,
  input wire logic [1:0] rate_select_out,
  input wire logic precomp_disable_flag,
  input wire logic density_select_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [1:0] md_reg;
  wire logic acc = !avs_waitrequest;
  wire logic din_rd = avs_read && acc && avs_address == 10'h3f7;
  // Shadow of the mode identity and encoding bits
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      md_reg <= 2'h1;
    end else if (avs_write && acc && avs_byteenable[0] && avs_address == 10'h3f8) begin
      md_reg <= avs_writedata[1:0];
    end
  end
  chk_hw_rst_vals: assert property (disable iff (1'b0) srst |=>
    {rate_select_out, precomp_disable_flag, density_select_out} == 4'h9)
    else $error("values after hardware reset wrong");
  chk_soft_keep: assert property (soft_rst && avs_waitrequest |=>
    $stable({rate_select_out, precomp_disable_flag, density_select_out}))
    else $error("soft reset changed rate settings");
  chk_rate_load: assert property (avs_write && acc && avs_byteenable[0] &&
    avs_address == 10'h3f7 |=> rate_select_out == $past(avs_writedata[1:0]))
    else $error("rate select not loaded");
  chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> acc)
    else $error("request not answered after one wait");
  chk_oe_idle: assert property (acc |=> dbus_oe_n == 8'hff)
    else $error("data bus not released");
  chk_write_no_drive: assert property (avs_write |-> dbus_oe_n == 8'hff)
    else $error("data bus driven during write");
  chk_at_view: assert property (din_rd |-> dbus_oe_n == (md_reg[0] ? 8'h7f : 8'h00))
    else $error("input view drive mask wrong");
  chk_alt_view: assert property (din_rd && md_reg == 2'h2 |->
    avs_readdata[6:0] == {4'hf, rate_select_out, ^rate_select_out})
    else $error("alternate view bits wrong");
  chk_third_view: assert property (din_rd && md_reg == 2'h0 |-> avs_readdata[6:4] == 3'h0 &&
    avs_readdata[2:0] == {precomp_disable_flag, rate_select_out})
    else $error("third view bits wrong");
  chk_st0_bit3: assert property (avs_read && acc && avs_address == 10'h3f9 |->
    !avs_readdata[3])
    else $error("status 0 bit 3 set");
  chk_st1_unused: assert property (avs_read && acc && avs_address == 10'h3fa |->
    !avs_readdata[6] && !avs_readdata[3])
    else $error("status 1 unused bit set");
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [13:0] ev = 14'h0000;
  logic [8:0] lv = 9'h100;
  logic [1:0] tc = 2'h0;
  logic [7:0] v;
  logic [9:0] tbl [4] = '{10'h1f4, 10'h12c, 10'h0fa, 10'h3e8};
  wire logic [9:0] a;
  wire logic [9:0] kb;
  wire logic [31:0] wd;
  wire logic [31:0] q;
  wire logic [3:0] be;
  wire logic [7:0] oe;
  wire logic [1:0] rs;
  wire logic rd, wr, wq, pc, dn;
  int error_cnt = 0;
  int n_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  frdis_core dut_u (.sys_clk(sys_clk), .srst(srst), .soft_rst(ev[13]), .avs_address(a),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(q), .avs_waitrequest(wq), .dbus_oe_n(oe), .disk_changed(lv[0]),
    .track_zero_input(lv[1]), .index_input(lv[2]), .write_protect_in(lv[3]),
    .dma_gate_enable(lv[4]), .cmd_start(ev[6]), .cmd_end(ev[7]), .termination_code(tc),
    .head_number(lv[8]), .drive_number(~tc), .seek_finished_ev(ev[0]),
    .recal_active(lv[5]), .recal_step(ev[9]), .rel_seek_past_zero(ev[1]),
    .beyond_last_sector(ev[2]), .data_xfer_done(ev[8]), .terminal_count(ev[12]),
    .crc_fault_ev(ev[3]), .overrun_ev(ev[4]), .sector_not_found_ev(ev[5]),
    .write_cmd_active(lv[6]), .id_search_active(lv[7]), .id_mark_found(ev[10]),
    .data_mark_missing(ev[11]), .rate_select_out(rs), .rate_kbps_out(kb),
    .precomp_disable_flag(pc), .density_select_out(dn));
  frdis_host host_u (.sys_clk(sys_clk), .avs_waitrequest(wq), .avs_readdata(q),
    .avs_address(a), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be));
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task pls(input int i);
    @(posedge sys_clk) ev[i] <= 1'b1;
    @(posedge sys_clk) ev[i] <= 1'b0;
  endtask
  task w8(input logic [9:0] ad, input logic [7:0] d);
    host_u.xfer(1'b1, ad, d, v);
  endtask
  task r8(input logic [9:0] ad, input logic [7:0] e);
    host_u.xfer(1'b0, ad, 8'h00, v);
    chk({24'h000000, v}, {24'h000000, e});
  endtask
  task close_out;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    chk({rs, pc, dn}, 4'h9);
    chk(kb, 10'h0fa);
    r8(10'h3f7, 8'h80);
    w8(10'h3f8, 8'h02);
    for (int r = 0; r < 4; r++) begin
      w8(10'h3f7, r[7:0]);
      r8(10'h3f7, {5'h1f, r[1:0], r[0] ^ r[1]});
      repeat (2) @(negedge sys_clk);
      chk({kb, rs, dn}, {tbl[r], r[1:0], r[0] == r[1]});
    end
    @(posedge sys_clk) lv[0] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    r8(10'h3f7, 8'h7e);
    w8(10'h3f8, 8'h0e);
    r8(10'h3f7, 8'hfe);
    w8(10'h3f8, 8'h00);
    @(posedge sys_clk) lv[4] <= 1'b1;
    w8(10'h3f7, 8'h05);
    r8(10'h3f7, 8'h0d);
    pls(13);
    repeat (2) @(negedge sys_clk);
    chk({rs, pc, dn}, 4'h6);
    r8(10'h3f7, 8'h0d);
    for (int c = 0; c < 4; c++) begin
      pls(6);
      tc <= c[1:0];
      pls(7);
      pls(0);
      if (c == 3) pls(1);
      r8(10'h3f9, {c[1:0], 1'b1, c == 3, 2'h1, ~c[1:0]});
    end
    pls(6);
    @(posedge sys_clk) lv <= lv | 9'h0c8;
    for (int i = 3; i < 6; i++) pls(i);
    pls(8);
    repeat (2) begin
      @(posedge sys_clk) lv[2] <= 1'b1;
      repeat (5) @(posedge sys_clk);
      lv[2] <= 1'b0;
      repeat (5) @(posedge sys_clk);
    end
    r8(10'h3fa, 8'hb7);
    // Terminal count seen before transfer end keeps end of track clear
    pls(6);
    pls(12);
    pls(8);
    r8(10'h3fa, 8'h03);
    pls(2);
    r8(10'h3fa, 8'h83);
    // Recalibrate with track zero never reached: fault only at step 80
    pls(6);
    @(posedge sys_clk) lv[5] <= 1'b1;
    repeat (79) pls(9);
    r8(10'h3f9, 8'h04);
    pls(9);
    r8(10'h3f9, 8'h14);
    r8(10'h100, 8'h00);
    @(posedge sys_clk) srst <= 1'b1;
    @(posedge sys_clk) srst <= 1'b0;
    @(negedge sys_clk);
    chk({rs, pc, dn}, 4'h9);
    // Synchroniser restarts from zero; let the high pin settle again
    repeat (6) @(posedge sys_clk);
    r8(10'h3f7, 8'h00);
    close_out;
  end
endmodule
bind frdis_core frdis_props #(.ADDR_W(ADDR_W)) props_u (.sys_clk(sys_clk), .srst(srst),
  .soft_rst(soft_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dbus_oe_n(dbus_oe_n),
  .rate_select_out(rate_select_out), .precomp_disable_flag(precomp_disable_flag),
  .density_select_out(density_select_out));
`default_nettype wire
